// ### ccac_params.svh
// ccac_params.svh: offsets, reset values, field positions and timing
// assumes inclusion by bare name from the design files
`ifndef CCAC_PARAMS_SVH
`define CCAC_PARAMS_SVH

// 7-bit bus address, fixed in silicon
`define CCAC_I2C_ADDR   7'h64

// register sub-addresses
`define CCAC_SUB_CFG    8'h01
`define CCAC_SUB_THR    8'h02
`define CCAC_SUB_ACC    8'h03
`define CCAC_SUB_FLG    8'h04
`define CCAC_SUB_INT    8'h05

// reset values
`define CCAC_CFG_RST    8'h00
`define CCAC_THR_RST    8'hFF
`define CCAC_INT_RST    1'b0

// config fields
`define CCAC_CFG_VEN    7
`define CCAC_CFG_VHI    6
`define CCAC_CFG_VLO    4
`define CCAC_CFG_MHI    3
`define CCAC_CFG_MLO    0

// interrupt control fields
`define CCAC_INT_CLR    0
`define CCAC_INT_TST    1

// alarm flag fields
`define CCAC_FLG_ONT    0
`define CCAC_FLG_OVF    1
`define CCAC_FLG_THR    2

// timing: pin release after a retrip, and core clock period
`define CCAC_HOLD_NS    1000
`define CCAC_CLK_NS     100

`endif

// ### ccac_pkg.sv
// ccac_pkg: types shared by the coulomb counter alarm control
// assumes nothing beyond a SystemVerilog compiler
package ccac_pkg;

   // serial slave states
   typedef enum logic [3:0] {
      I_IDLE = 4'b0000,
      I_ADDR = 4'b0001,
      I_AACK = 4'b0010,
      I_SUB  = 4'b0011,
      I_SACK = 4'b0100,
      I_WR   = 4'b0101,
      I_WACK = 4'b0110,
      I_RD   = 4'b0111,
      I_RACK = 4'b1000
   } ccac_i2c_t;

endpackage : ccac_pkg

// ### ccac_core.sv
// ccac_core: coulomb counter chain, alarm control, serial register port
// assumes charge strobe, value and timeout come from core_clk logic;
// scl, sda, bus supply, enable and select pins are asynchronous
`timescale 1ns/10ps
`default_nettype none
`include "ccac_params.svh"

module ccac_core
   import ccac_pkg::*;
#(
   parameter int ChainW = 50,
   parameter int AddW   = 8
)(
   input  wire logic            core_clk,
   input  wire logic            rst_b,
   input  wire logic            sclIn,
   input  wire logic            sdaIn,
   output logic                 sdaOut,
   output logic                 sdaOe,
   input  wire logic            busSupplyOk,
   input  wire logic [2:0]      outSelPin,
   output logic      [2:0]      vOutSel,
   input  wire logic            convEnable,
   input  wire logic            chargeStrobe,
   input  wire logic [AddW-1:0] chargeValue,
   input  wire logic            onTimeOver,
   output logic                 irqN
);

   localparam int HoldCyc = `CCAC_HOLD_NS / `CCAC_CLK_NS;

   typedef struct packed {
      logic [1:0]        sclS;
      logic [1:0]        sdaS;
      logic [1:0]        okS;
      logic [1:0]        enS;
      logic              sclD;
      logic              sdaD;
      logic [2:0]        pin0;
      logic [2:0]        pin1;
      ccac_i2c_t         st;
      logic [3:0]        cnt;
      logic [7:0]        sh;
      logic [7:0]        sub;
      logic              rw;
      logic              oe;
      logic [7:0]        cfg;
      logic [7:0]        thr;
      logic              tst;
      logic              clr;
      logic [3:0]        hold;
      logic [2:0]        flags;
      logic              ovfCond;
      logic              mChg;
      logic              evalPend;
      logic              rip;
      logic [ChainW-1:0] chain;
      logic [2:0]        vSel;
      logic              irqN;
   } ccac_st_t;

   ccac_st_t s_q;
   ccac_st_t s_d;

   logic              wrEv;
   logic              wrC;
   logic              clrEv;
   logic              strobeEn;
   logic              ovfNow;
   logic              thrHit;
   logic              sclR;
   logic              sclF;
   logic              sclHi;
   logic [ChainW:0]   sum;
   logic [AddW:0]     lowSum;
   logic [7:0]        rdData;

   // readable window: prescaler shortens the chain from the top
   function automatic logic [7:0] winOf(input logic [ChainW-1:0] c,
                                        input logic [3:0]        m);
      winOf = 8'(c >> (ChainW - 8 - int'(m)));
   endfunction : winOf

   function automatic logic [ChainW:0] maskOf(input logic [3:0] m);
      maskOf = {(ChainW + 1){1'b1}} >> (int'(m) + 1);
   endfunction : maskOf

   function automatic logic [ChainW-1:0] placeOf(
      input logic [ChainW-1:0] c,
      input logic [3:0]        m,
      input logic [7:0]        w);
      int sft;
      sft = ChainW - 8 - int'(m);
      placeOf = (c & ~(ChainW'(8'hFF) << sft)) | (ChainW'(w) << sft);
   endfunction : placeOf

   assign sdaOut  = 1'b0;
   assign sdaOe   = s_q.oe;
   assign vOutSel = s_q.vSel;
   assign irqN    = s_q.irqN;

   always_comb begin
      s_d      = s_q;
      wrEv     = 1'b0;
      wrC      = 1'b0;
      clrEv    = 1'b0;
      thrHit   = 1'b0;
      s_d.sclS = {s_q.sclS[0], sclIn};
      s_d.sdaS = {s_q.sdaS[0], sdaIn};
      s_d.okS  = {s_q.okS[0], busSupplyOk};
      s_d.enS  = {s_q.enS[0], convEnable};
      s_d.pin0 = outSelPin;
      s_d.pin1 = s_q.pin0;
      s_d.sclD = s_q.sclS[1];
      s_d.sdaD = s_q.sdaS[1];
      sclR     = s_q.sclS[1] & ~s_q.sclD;
      sclF     = ~s_q.sclS[1] & s_q.sclD;
      sclHi    = s_q.sclS[1] & s_q.sclD;

      case (s_q.sub)
         `CCAC_SUB_ACC: rdData = winOf(s_q.chain, s_q.cfg[3:0]);
         `CCAC_SUB_FLG: rdData = {5'h00, s_q.flags};
         default:       rdData = 8'h00;
      endcase

      // serial slave; low bus supply holds it idle
      if (!s_q.okS[1]) begin
         s_d.st = I_IDLE;
         s_d.oe = 1'b0;
      end else if (sclHi && s_q.sdaD && !s_q.sdaS[1]) begin
         s_d.st  = I_ADDR;
         s_d.cnt = 4'h0;
         s_d.oe  = 1'b0;
      end else if (sclHi && !s_q.sdaD && s_q.sdaS[1]) begin
         s_d.st = I_IDLE;
         s_d.oe = 1'b0;
      end else if (sclR) begin
         if (s_q.st == I_ADDR || s_q.st == I_SUB || s_q.st == I_WR) begin
            s_d.sh  = {s_q.sh[6:0], s_q.sdaS[1]};
            s_d.cnt = s_q.cnt + 4'h1;
         end else if (s_q.st == I_RD) begin
            s_d.cnt = s_q.cnt + 4'h1;
         end else if (s_q.st == I_RACK && s_q.sdaS[1]) begin
            s_d.st = I_IDLE;
         end
      end else if (sclF) begin
         case (s_q.st)
            I_ADDR: begin
               if (s_q.cnt == 4'h8) begin
                  if (s_q.sh[7:1] == `CCAC_I2C_ADDR) begin
                     s_d.st = I_AACK;
                     s_d.oe = 1'b1;
                     s_d.rw = s_q.sh[0];
                  end else begin
                     s_d.st = I_IDLE;
                  end
               end
            end
            I_AACK: begin
               s_d.cnt = 4'h0;
               if (s_q.rw) begin
                  s_d.st = I_RD;
                  s_d.sh = rdData;
                  s_d.oe = ~rdData[7];
               end else begin
                  s_d.st = I_SUB;
                  s_d.oe = 1'b0;
               end
            end
            I_SUB: begin
               if (s_q.cnt == 4'h8) begin
                  s_d.sub = s_q.sh;
                  s_d.st  = I_SACK;
                  s_d.oe  = 1'b1;
               end
            end
            I_SACK, I_WACK: begin
               s_d.st  = I_WR;
               s_d.oe  = 1'b0;
               s_d.cnt = 4'h0;
            end
            I_WR: begin
               if (s_q.cnt == 4'h8) begin
                  wrEv   = 1'b1;
                  s_d.st = I_WACK;
                  s_d.oe = 1'b1;
               end
            end
            I_RD: begin
               if (s_q.cnt == 4'h8) begin
                  s_d.st = I_RACK;
                  s_d.oe = 1'b0;
               end else begin
                  s_d.sh = {s_q.sh[6:0], 1'b0};
                  s_d.oe = ~s_q.sh[6];
               end
            end
            I_RACK: begin
               s_d.st  = I_RD;
               s_d.cnt = 4'h0;
               s_d.sh  = rdData;
               s_d.oe  = ~rdData[7];
            end
            default: s_d.st = I_IDLE;
         endcase
      end

      // register writes; the host may retune the select at any time
      if (wrEv) begin
         case (s_q.sub)
            `CCAC_SUB_CFG: begin
               s_d.cfg = s_q.sh;
               if (s_q.sh[3:0] != s_q.cfg[3:0])
                  s_d.mChg = 1'b1;
            end
            `CCAC_SUB_THR: s_d.thr = s_q.sh;
            `CCAC_SUB_ACC: wrC = 1'b1;
            `CCAC_SUB_INT: begin
               s_d.tst = s_q.sh[`CCAC_INT_TST];
               clrEv   = s_q.sh[`CCAC_INT_CLR];
            end
            default: ;
         endcase
      end

      // chain advances on every on-pulse only while convEnable is high; a counter write wins
      strobeEn = chargeStrobe & s_q.enS[1];
      lowSum   = (AddW + 1)'(s_q.chain[AddW-1:0]) + (AddW + 1)'(chargeValue);
      sum      = {1'b0, s_q.chain} + (ChainW + 1)'(chargeValue);
      ovfNow   = strobeEn && !wrC &&
                 |(sum & ~maskOf(s_q.cfg[3:0]));
      if (wrC) begin
         s_d.chain = placeOf(s_q.chain, s_q.cfg[3:0], s_q.sh);
         if (s_q.mChg && s_q.sh < winOf(s_q.chain, s_q.cfg[3:0])) begin
            s_d.ovfCond = 1'b0;
            s_d.mChg    = 1'b0;
         end
      end else if (strobeEn) begin
         s_d.chain = ChainW'(sum & maskOf(s_q.cfg[3:0]));
         if (lowSum[AddW])
            s_d.rip = ~s_q.rip;
      end
      if (ovfNow)
         s_d.ovfCond = 1'b1;

      // threshold looks at the chain one cycle after it moved
      s_d.evalPend = strobeEn | wrC;
      thrHit = s_q.evalPend &&
               winOf(s_q.chain, s_q.cfg[3:0]) >= s_q.thr;

      // clear, then new causes: a same-cycle set wins
      if (clrEv) begin
         s_d.flags = 3'h0;
         s_d.clr   = 1'b1;
         s_d.hold  = 4'(HoldCyc);
      end else if (s_q.hold != 4'h0) begin
         s_d.hold = s_q.hold - 4'h1;
         if (s_q.hold == 4'h1)
            s_d.clr = 1'b0;
      end
      s_d.flags[`CCAC_FLG_ONT] = s_d.flags[`CCAC_FLG_ONT] |
                                 (strobeEn & onTimeOver);
      s_d.flags[`CCAC_FLG_OVF] = s_d.flags[`CCAC_FLG_OVF] |
                                 s_q.ovfCond;
      s_d.flags[`CCAC_FLG_THR] = s_d.flags[`CCAC_FLG_THR] | thrHit;

      if (s_q.cfg[`CCAC_CFG_VEN])
         s_d.vSel = s_q.cfg[`CCAC_CFG_VHI:`CCAC_CFG_VLO];
      else
         s_d.vSel = s_q.pin1;

      if (s_q.tst)
         s_d.irqN = s_q.rip;
      else
         s_d.irqN = !(|s_q.flags && s_q.hold == 4'h0);
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q      <= '0;
         s_q.cfg  <= `CCAC_CFG_RST;
         s_q.thr  <= `CCAC_THR_RST;
         s_q.tst  <= `CCAC_INT_RST;
         s_q.clr  <= `CCAC_INT_RST;
         s_q.sclS <= 2'h3;
         s_q.sdaS <= 2'h3;
         s_q.sclD <= 1'b1;
         s_q.sdaD <= 1'b1;
         s_q.irqN <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   AST_VSEL_REG: assert property (
      s_q.cfg[7] && $stable(s_q.cfg) |=> vOutSel == $past(s_q.cfg[6:4]))
      else $error("register select not applied");
   AST_VSEL_PIN: assert property (
      !s_q.cfg[7] && $stable(s_q.pin1) |=> vOutSel == $past(s_q.pin1))
      else $error("pin select not followed");
   AST_TEST_IRQ: assert property (
      s_q.tst && $stable(s_q.tst) |=> irqN == $past(s_q.rip))
      else $error("test mode irq not ripple clock");
   AST_ALARM_LOW: assert property (
      !s_q.tst && |s_q.flags && s_q.hold == 4'h0 |=> !irqN)
      else $error("alarm did not pull irq low");
   AST_SELF_CLR: assert property (
      $rose(s_q.clr) |-> ##[1:12] !s_q.clr)
      else $error("clear bit did not self-clear");
   AST_RELEASE: assert property (
      $rose(s_q.clr) && !s_q.tst |=> irqN [*8])
      else $error("irq not released after clear");
   AST_ONTIME: assert property (
      strobeEn && onTimeOver |=> s_q.flags[0])
      else $error("on-time timeout flag missing");
   AST_OVF: assert property (
      s_q.ovfCond |=> s_q.flags[1])
      else $error("overflow flag missing");
   AST_THR: assert property (
      s_q.evalPend && winOf(s_q.chain, s_q.cfg[3:0]) >= s_q.thr
      |=> s_q.flags[2])
      else $error("threshold flag missing");
   AST_NO_EVAL: assert property (
      !s_q.evalPend && !clrEv |=> s_q.flags[2] == $past(s_q.flags[2]))
      else $error("threshold flag moved without check");
   AST_RETAIN: assert property (
      !s_q.enS[1] && !wrC |=> $stable(s_q.chain))
      else $error("chain changed while disabled");
   AST_BUS_OFF: assert property (
      !s_q.okS[1] |=> s_q.st == I_IDLE && !sdaOe)
      else $error("bus active with low bus supply");
   AST_ADD: assert property (
      strobeEn && !wrC
      |=> s_q.chain[7:0] == 8'($past(s_q.chain[7:0]) + $past(chargeValue)))
      else $error("adder result wrong");

   COV_RETRIP: cover property ($rose(s_q.clr) && |s_d.flags);
   COV_THR: cover property ($rose(s_q.flags[2]));
   COV_TEST: cover property (s_q.tst && $changed(irqN));
   COV_READ: cover property (s_q.st == I_RACK && sclF);

endmodule : ccac_core

`default_nettype wire

// ### ccac_i2c_host.sv
// ccac_i2c_host: behavioural bus host for the register port
// assumes a pull-up on the data line; paced by core_clk
`timescale 1ns/10ps
`default_nettype none
`include "ccac_params.svh"

module ccac_i2c_host (
   input  wire logic core_clk,
   input  wire logic sdaOe,
   input  wire logic sdaOut,
   output logic      scl,
   output logic      sda
);
   logic hostLow = 1'b0;
   int   phase   = 8;

   // pull-up wins unless a party pulls low
   assign sda = !hostLow && (sdaOe ? sdaOut : 1'b1);
   initial scl = 1'b1;

   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : hold

   // data moves 2 cycles after the fall, never beside a clock edge
   task automatic clkBit(input logic low, output logic seen);
      hostLow = low;
      hold(phase);
      scl = 1'b1;
      hold(phase);
      seen = sda;
      scl = 1'b0;
      hold(2);
   endtask : clkBit

   task automatic byteX(input logic [7:0] tx, output logic [7:0] rx,
                        output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         clkBit(!tx[i], rx[i]);
      end
      clkBit(1'b0, a);
      ack = !a;
   endtask : byteX

   // doubles as repeated start
   task automatic start();
      hostLow = 1'b0;
      hold(phase);
      scl = 1'b1;
      hold(phase);
      hostLow = 1'b1;
      hold(phase);
      scl = 1'b0;
      hold(2);
   endtask : start

   task automatic stop();
      hostLow = 1'b1;
      hold(phase);
      scl = 1'b1;
      hold(phase);
      hostLow = 1'b0;
      hold(phase);
   endtask : stop

   task automatic access(input logic [7:0] sub, input logic [7:0] wd,
                         input logic rd, output logic [7:0] q,
                         output logic [2:0] acks);
      logic [7:0] rx;
      start();
      byteX({`CCAC_I2C_ADDR, 1'b0}, rx, acks[2]);
      byteX(sub, rx, acks[1]);
      if (rd) begin
         start();
         byteX({`CCAC_I2C_ADDR, 1'b1}, rx, acks[0]);
         byteX(8'hFF, q, rx[0]);
      end else begin
         byteX(wd, q, acks[0]);
      end
      stop();
   endtask : access
endmodule : ccac_i2c_host
`default_nettype wire

// ### testbench.sv
// testbench: self-checking bench for ccac_core
// assumes ccac_i2c_host as bus host; charge strobes made here
`timescale 1ns/10ps
`default_nettype none
`include "ccac_params.svh"

module testbench;
   logic       core_clk, rst_b, scl, sda, sdaOut, sdaOe, irqN;
   logic       busSupplyOk, convEnable, chargeStrobe, onTimeOver;
   logic [2:0] outSelPin, vOutSel;
   logic [7:0] chargeValue;
   int         fails, testsRun, cycles;
   int         irqHighCnt;

   ccac_i2c_host host_i (.core_clk(core_clk), .sdaOe(sdaOe), .scl(scl),
                         .sda(sda), .sdaOut(sdaOut));
   ccac_core ccac_core_i (.core_clk(core_clk), .rst_b(rst_b), .sclIn(scl),
      .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .busSupplyOk(busSupplyOk), .outSelPin(outSelPin),
      .vOutSel(vOutSel), .convEnable(convEnable),
      .chargeStrobe(chargeStrobe), .chargeValue(chargeValue),
      .onTimeOver(onTimeOver), .irqN(irqN));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic completeRun();
      $display("checks %0d mismatches %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : completeRun

   // a hang costs a mismatch, then the closing report
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         completeRun();
      end
   end

   // cycles with the pin released, to time the retrip window
   always @(posedge core_clk) begin
      if (irqN === 1'b1) begin
         irqHighCnt++;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      testsRun++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic chkIrq(input logic e);
      check("irqN", {7'h00, e}, {7'h00, irqN});
   endtask : chkIrq

   task automatic wr(input logic [7:0] sub, input logic [7:0] d,
                     input logic [2:0] expAck);
      logic [7:0] q;
      logic [2:0] a;
      host_i.access(sub, d, 1'b0, q, a);
      check("ack", {5'h00, expAck}, {5'h00, a});
   endtask : wr

   task automatic rd(input logic [7:0] sub, input logic [7:0] exp);
      logic [7:0] q;
      logic [2:0] a;
      host_i.access(sub, 8'h00, 1'b1, q, a);
      check("ack", 8'h07, {5'h00, a});
      check("read", exp, q);
   endtask : rd

   task automatic pulse(input logic [7:0] v, input logic over);
      chargeStrobe = 1'b1;
      chargeValue = v;
      onTimeOver = over;
      tick(1);
      chargeStrobe = 1'b0;
      onTimeOver = 1'b0;
      tick(5);
   endtask : pulse

   task automatic tResetState();
      rd(`CCAC_SUB_ACC, 8'h00);
      rd(`CCAC_SUB_FLG, 8'h00);
      chkIrq(1'b1);
      check("vOutSel", 8'h06, {5'h00, vOutSel});
   endtask : tResetState

   task automatic tOutSel();
      logic [7:0] cfg [4] = '{8'h30, 8'hB0, 8'hC0, 8'hD0};
      logic [2:0] exp [4] = '{3'h6, 3'h3, 3'h4, 3'h5};
      for (int i = 0; i < 4; i++) begin
         wr(`CCAC_SUB_CFG, cfg[i], 3'h7);
         tick(3);
         check("vOutSel", {5'h00, exp[i]}, {5'h00, vOutSel});
      end
      wr(`CCAC_SUB_CFG, 8'h00, 3'h7);
   endtask : tOutSel

   // test mode: pin toggles once per adder carry
   task automatic tCounter();
      logic lvl;
      wr(`CCAC_SUB_INT, 8'h02, 3'h7);
      tick(3);
      lvl = irqN;
      pulse(8'h80, 1'b0);
      chkIrq(lvl);
      pulse(8'h80, 1'b0);
      chkIrq(!lvl);
      convEnable = 1'b0;
      tick(4);
      pulse(8'hC0, 1'b0);
      chkIrq(!lvl);
      convEnable = 1'b1;
      tick(4);
      pulse(8'h80, 1'b0);
      chkIrq(!lvl);
      pulse(8'h80, 1'b0);
      chkIrq(lvl);
      wr(`CCAC_SUB_INT, 8'h00, 3'h7);
      tick(3);
      chkIrq(1'b1);
   endtask : tCounter

   task automatic tPrescale();
      wr(`CCAC_SUB_CFG, 8'h0F, 3'h7);
      wr(`CCAC_SUB_ACC, 8'h40, 3'h7);
      rd(`CCAC_SUB_ACC, 8'h40);
      wr(`CCAC_SUB_CFG, 8'h0E, 3'h7);
      rd(`CCAC_SUB_ACC, 8'h20);
   endtask : tPrescale

   task automatic tThreshold();
      wr(`CCAC_SUB_THR, 8'h20, 3'h7);
      chkIrq(1'b1);
      wr(`CCAC_SUB_ACC, 8'h1F, 3'h7);
      tick(4);
      chkIrq(1'b1);
      wr(`CCAC_SUB_ACC, 8'h20, 3'h7);
      tick(4);
      chkIrq(1'b0);
      rd(`CCAC_SUB_FLG, 8'h04);
      wr(`CCAC_SUB_INT, 8'h01, 3'h7);
      tick(20);
      chkIrq(1'b1);
      rd(`CCAC_SUB_FLG, 8'h00);
      pulse(8'h00, 1'b0);
      chkIrq(1'b0);
      wr(`CCAC_SUB_THR, 8'hFF, 3'h7);
      wr(`CCAC_SUB_INT, 8'h01, 3'h7);
      tick(20);
      chkIrq(1'b1);
   endtask : tThreshold

   task automatic tOnTime();
      pulse(8'h00, 1'b1);
      chkIrq(1'b0);
      rd(`CCAC_SUB_FLG, 8'h01);
      wr(`CCAC_SUB_INT, 8'h01, 3'h7);
      tick(20);
      pulse(8'h00, 1'b0);
      chkIrq(1'b1);
      rd(`CCAC_SUB_FLG, 8'h00);
   endtask : tOnTime

   task automatic tBus();
      logic [7:0] q;
      logic       a;
      host_i.phase = 12;
      host_i.start();
      host_i.byteX(8'hA0, q, a);
      host_i.stop();
      check("ack", 8'h00, {7'h00, a});
      busSupplyOk = 1'b0;
      tick(4);
      wr(`CCAC_SUB_CFG, 8'hF0, 3'h0);
      pulse(8'h00, 1'b1);
      chkIrq(1'b0);
      busSupplyOk = 1'b1;
      tick(4);
      check("vOutSel", 8'h06, {5'h00, vOutSel});
      rd(`CCAC_SUB_FLG, 8'h01);
   endtask : tBus

   // bits above a shortened chain overflow; cause re-flags until rewound
   task automatic tOverflow();
      wr(`CCAC_SUB_INT, 8'h01, 3'h7);
      wr(`CCAC_SUB_ACC, 8'h80, 3'h7);
      wr(`CCAC_SUB_CFG, 8'h0F, 3'h7);
      pulse(8'h00, 1'b0);
      chkIrq(1'b0);
      rd(`CCAC_SUB_FLG, 8'h02);
      irqHighCnt = 0;
      wr(`CCAC_SUB_INT, 8'h01, 3'h7);
      check("irqHigh", 8'(`CCAC_HOLD_NS / `CCAC_CLK_NS),
            8'(irqHighCnt));
      chkIrq(1'b0);
      rd(`CCAC_SUB_FLG, 8'h02);
      wr(`CCAC_SUB_ACC, 8'h10, 3'h7);
      wr(`CCAC_SUB_CFG, 8'h0E, 3'h7);
      wr(`CCAC_SUB_ACC, 8'h00, 3'h7);
      wr(`CCAC_SUB_INT, 8'h01, 3'h7);
      tick(20);
      chkIrq(1'b1);
      rd(`CCAC_SUB_FLG, 8'h00);
   endtask : tOverflow

   initial begin
      rst_b = 1'b0;
      busSupplyOk = 1'b1;
      convEnable = 1'b1;
      chargeStrobe = 1'b0;
      chargeValue = 8'h00;
      onTimeOver = 1'b0;
      outSelPin = 3'h6;
      fails = 0;
      testsRun = 0;
      cycles = 0;
      tick(4);
      rst_b = 1'b1;
      tick(4);
      tResetState();
      tOutSel();
      tCounter();
      tPrescale();
      tThreshold();
      tOnTime();
      tBus();
      tOverflow();
      completeRun();
   end
endmodule : testbench
`default_nettype wire
